/* ocr_params.svh */
`ifndef OCR_PARAMS_SVH
`define OCR_PARAMS_SVH

// command codes and reset values
`define OCR_CMD_OC_CFG      8'h47
`define OCR_CMD_DIE_CFG     8'hD6
`define OCR_OC_CFG_RESET    8'h00
`define OCR_DIE_CFG_VALUE   8'hC0

// field positions of the overcurrent action byte
`define OCR_RESP_HI         7
`define OCR_RESP_LO         6
`define OCR_RETRY_HI        5
`define OCR_RETRY_LO        3
`define OCR_DELAY_HI        2
`define OCR_DELAY_LO        0
`define OCR_RETRY_FOREVER   3'h7
`define OCR_RETRY_NONE      3'h0

// timing
`define OCR_CLK_PERIOD_NS   5
`define OCR_MS_NS           1000000
`define OCR_MS_CYCLES       (`OCR_MS_NS / `OCR_CLK_PERIOD_NS)
`define OCR_DELAY_UNIT_MS   16

`endif

/* ocr_pkg.sv */
package ocr_pkg;

  typedef enum logic [1:0] {
    OCR_RESP_CC    = 2'h0,
    OCR_RESP_UNSUP = 2'h1,
    OCR_RESP_DELAY = 2'h2,
    OCR_RESP_SHUT  = 2'h3
  } ocr_resp_type;

  typedef enum logic [2:0] {
    OCR_ST_OFF,
    OCR_ST_RUN,
    OCR_ST_LIMIT,
    OCR_ST_LATCHED,
    OCR_ST_RETRY,
    OCR_ST_HALT
  } ocr_state_type;

endpackage

/* ocr_overcurrent_response.sv */
`timescale 1ns/100ps
`include "ocr_params.svh"

module ocr_overcurrent_response
#(
  parameter int   MS_TICK_CYCLES = `OCR_MS_CYCLES,
  parameter logic PAGE_ID        = 1'b0
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // command port
  input  wire logic        page,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        wr_strobe,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_strobe,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             cmd_reject,
  // fault clearing commands and nvm image
  input  wire logic        clear_faults,
  input  wire logic        restore_user_all,
  input  wire logic        vendor_soft_reset_cmd,
  input  wire logic [7:0]  nvm_cfg,
  // channel control
  input  wire logic        run_pin,
  input  wire logic        operation_on,
  input  wire logic        oc_detect,
  input  wire logic        other_fault_shutdown,
  input  wire logic        alert_mask,
  input  wire logic [15:0] restart_interval_setting,
  // channel outputs
  output logic             output_enable,
  output logic             current_limit_active,
  // status bits
  output logic             status_none_of_above,
  output logic             status_iout_oc,
  output logic             status_word_iout,
  output logic             status_iout_oc_fault,
  // open-drain alert, active low on the wire
  output logic             smbalert_out,
  output logic             smbalert_oe
);

  localparam logic [17:0] MS_LAST = 18'(MS_TICK_CYCLES - 1);

  logic [7:0]             cfg_r;
  logic [17:0]            ms_cnt_r;
  logic [15:0]            wait_r;
  logic                   cmd_on_q_r;
  logic                   oc_q_r;
  logic                   fault_r;
  logic                   alert_r;
  logic [7:0]             rd_data_r;
  logic                   rd_valid_r;
  logic                   cmd_reject_r;
  ocr_pkg::ocr_state_type state_r;
  ocr_pkg::ocr_resp_type  resp;
  logic [2:0]             retry_sel;
  logic [2:0]             delay_sel;
  logic                   cmd_on;
  logic                   on_cycle;
  logic                   clear_evt;
  logic                   reload;
  logic                   cfg_wr_ok;
  logic                   ms_tick;
  logic                   fault_event;
  logic                   limit_expire;
  logic                   tmr_load;

  // unsupported 01 behaves as constant-current
  function automatic ocr_pkg::ocr_resp_type resp_of(input logic [7:0] v);
    logic [1:0] r;
    r = v[`OCR_RESP_HI:`OCR_RESP_LO];
    if (r == 2'h1)
      return ocr_pkg::OCR_RESP_CC;
    return ocr_pkg::ocr_resp_type'(r);
  endfunction

  // next state after a shutdown decision
  function automatic ocr_pkg::ocr_state_type after_shut(input logic [2:0] rt);
    if (rt == `OCR_RETRY_FOREVER)
      return ocr_pkg::OCR_ST_RETRY;
    return ocr_pkg::OCR_ST_LATCHED;
  endfunction

  assign resp      = resp_of(cfg_r);
  assign retry_sel = cfg_r[`OCR_RETRY_HI:`OCR_RETRY_LO];
  assign delay_sel = cfg_r[`OCR_DELAY_HI:`OCR_DELAY_LO];
  assign cmd_on    = run_pin & operation_on;
  assign on_cycle  = cmd_on & ~cmd_on_q_r;
  assign reload    = restore_user_all | vendor_soft_reset_cmd;
  assign clear_evt = clear_faults | reload | on_cycle;
  assign ms_tick   = (ms_cnt_r == MS_LAST);

  // writes with the unsupported response code are refused
  assign cfg_wr_ok = wr_strobe & (cmd_code == `OCR_CMD_OC_CFG)
                   & (page == PAGE_ID)
                   & (wr_data[`OCR_RESP_HI:`OCR_RESP_LO] != 2'h1);

  // constant-current keeps running, so only a fresh edge counts
  assign fault_event = (state_r == ocr_pkg::OCR_ST_RUN) & cmd_on
                     & ~other_fault_shutdown & oc_detect
                     & (~oc_q_r | (resp != ocr_pkg::OCR_RESP_CC));

  assign limit_expire = (state_r == ocr_pkg::OCR_ST_LIMIT) & cmd_on
                      & ~other_fault_shutdown & oc_detect
                      & (wait_r == 16'h0000);

  // timed waits start on a fresh millisecond boundary
  assign tmr_load = fault_event | limit_expire;

  // configuration byte
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cfg_r <= `OCR_OC_CFG_RESET;
    else if (reload)
      cfg_r <= nvm_cfg;
    else if (cfg_wr_ok)
      cfg_r <= wr_data;
  end

  // command port answers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_r    <= 8'h00;
      rd_valid_r   <= 1'b0;
      cmd_reject_r <= 1'b0;
    end
    else
    begin
      rd_valid_r   <= rd_strobe;
      cmd_reject_r <= wr_strobe & ~cfg_wr_ok
                    & ~((cmd_code == `OCR_CMD_OC_CFG) & (page != PAGE_ID));
      if (rd_strobe)
      begin
        if (cmd_code == `OCR_CMD_OC_CFG)
          rd_data_r <= cfg_r;
        else if (cmd_code == `OCR_CMD_DIE_CFG)
          rd_data_r <= `OCR_DIE_CFG_VALUE;
        else
          rd_data_r <= 8'h00;
      end
    end
  end

  // millisecond divider
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ms_cnt_r <= 18'h00000;
    else if (tmr_load || ms_tick)
      ms_cnt_r <= 18'h00000;
    else
      ms_cnt_r <= ms_cnt_r + 18'h00001;
  end

  // edge history
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_on_q_r <= 1'b0;
      oc_q_r     <= 1'b0;
    end
    else
    begin
      cmd_on_q_r <= cmd_on;
      oc_q_r     <= oc_detect;
    end
  end

  // channel sequencing
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ocr_pkg::OCR_ST_OFF;
      wait_r  <= 16'h0000;
    end
    else
    begin
      unique case (state_r)
        ocr_pkg::OCR_ST_OFF:
          if (cmd_on)
            state_r <= ocr_pkg::OCR_ST_RUN;
        ocr_pkg::OCR_ST_RUN:
          if (!cmd_on)
            state_r <= ocr_pkg::OCR_ST_OFF;
          else if (other_fault_shutdown)
            state_r <= ocr_pkg::OCR_ST_HALT;
          else if (fault_event)
          begin
            if (resp == ocr_pkg::OCR_RESP_DELAY)
            begin
              state_r <= ocr_pkg::OCR_ST_LIMIT;
              wait_r  <= 16'(delay_sel) * 16'(`OCR_DELAY_UNIT_MS);
            end
            else if (resp == ocr_pkg::OCR_RESP_SHUT)
            begin
              state_r <= after_shut(retry_sel);
              wait_r  <= restart_interval_setting;
            end
          end
        ocr_pkg::OCR_ST_LIMIT:
          if (!cmd_on)
            state_r <= ocr_pkg::OCR_ST_OFF;
          else if (other_fault_shutdown)
            state_r <= ocr_pkg::OCR_ST_HALT;
          else if (!oc_detect)
            state_r <= ocr_pkg::OCR_ST_RUN;
          else if (limit_expire)
          begin
            state_r <= after_shut(retry_sel);
            wait_r  <= restart_interval_setting;
          end
          else if (ms_tick)
            wait_r <= wait_r - 16'h0001;
        ocr_pkg::OCR_ST_LATCHED:
          if (!run_pin)
            state_r <= ocr_pkg::OCR_ST_OFF;
        ocr_pkg::OCR_ST_RETRY:
          if (!cmd_on)
            state_r <= ocr_pkg::OCR_ST_OFF;
          else if (other_fault_shutdown)
            state_r <= ocr_pkg::OCR_ST_HALT;
          else if (wait_r == 16'h0000)
            state_r <= ocr_pkg::OCR_ST_RUN;
          else if (ms_tick)
            wait_r <= wait_r - 16'h0001;
        ocr_pkg::OCR_ST_HALT:
          if (!cmd_on)
            state_r <= ocr_pkg::OCR_ST_OFF;
        default:
          state_r <= ocr_pkg::OCR_ST_OFF;
      endcase
    end
  end

  // sticky fault and alert, set wins over clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_r <= 1'b0;
      alert_r <= 1'b0;
    end
    else
    begin
      if (fault_event)
        fault_r <= 1'b1;
      else if (clear_evt)
        fault_r <= 1'b0;
      if (fault_event && !alert_mask)
        alert_r <= 1'b1;
      else if (clear_evt)
        alert_r <= 1'b0;
    end
  end

  assign output_enable = (state_r == ocr_pkg::OCR_ST_RUN)
                       | (state_r == ocr_pkg::OCR_ST_LIMIT);
  assign current_limit_active = oc_detect & output_enable
                       & ((resp == ocr_pkg::OCR_RESP_CC)
                          | (state_r == ocr_pkg::OCR_ST_LIMIT));

  assign status_none_of_above = fault_r;
  assign status_iout_oc       = fault_r;
  assign status_word_iout     = fault_r;
  assign status_iout_oc_fault = fault_r;
  assign smbalert_out         = 1'b0;
  assign smbalert_oe          = alert_r;
  assign rd_data              = rd_data_r;
  assign rd_valid             = rd_valid_r;
  assign cmd_reject           = cmd_reject_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_limit_expiry;
    limit_expire;
  endsequence

  sequence seq_output_off;
    !output_enable;
  endsequence

  chk_cfg_write_takes: assert property (
    cfg_wr_ok && !reload |=> cfg_r == $past(wr_data))
    else $error("config write not stored");

  chk_status_bits_set: assert property (
    fault_event |=> status_none_of_above && status_iout_oc
                    && status_word_iout && status_iout_oc_fault)
    else $error("status bits not set on fault");

  chk_alert_raise: assert property (
    fault_event && !alert_mask |=> smbalert_oe && !smbalert_out)
    else $error("alert not raised on fault");

  chk_fault_sticky: assert property (
    status_iout_oc_fault && !clear_evt |=> status_iout_oc_fault)
    else $error("fault bit dropped without a clear");

  chk_cc_stays_on: assert property (
    fault_event && resp == ocr_pkg::OCR_RESP_CC && !cfg_wr_ok && !reload
    |=> output_enable && current_limit_active == oc_detect)
    else $error("constant-current response left run");

  chk_delay_expiry: assert property (
    seq_limit_expiry |=> seq_output_off)
    else $error("output on after delay expiry");

  chk_shut_now: assert property (
    fault_event && resp == ocr_pkg::OCR_RESP_SHUT |=> seq_output_off)
    else $error("immediate shutdown not immediate");

  chk_latch_hold: assert property (
    state_r == ocr_pkg::OCR_ST_LATCHED && run_pin
    |=> state_r == ocr_pkg::OCR_ST_LATCHED)
    else $error("latched off restarted");

  chk_retry_resume: assert property (
    state_r == ocr_pkg::OCR_ST_RETRY && cmd_on && !other_fault_shutdown
    && wait_r == 16'h0000 |=> output_enable)
    else $error("retry did not restart");

  chk_retry_interval: assert property (
    ((fault_event && resp == ocr_pkg::OCR_RESP_SHUT) || limit_expire)
    && retry_sel == `OCR_RETRY_FOREVER
    |=> wait_r == $past(restart_interval_setting))
    else $error("retry interval not loaded");

  chk_die_read: assert property (
    rd_strobe && cmd_code == `OCR_CMD_DIE_CFG
    |=> rd_valid && rd_data == `OCR_DIE_CFG_VALUE)
    else $error("die overheat byte misread");

endmodule

/* ocr_host_model.sv */
`timescale 1ns/100ps
module ocr_host_model
(
  // clock and answers
  input  wire logic       core_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  input  wire logic       cmd_reject,
  // requests
  output logic            page,
  output logic      [7:0] cmd_code,
  output logic            wr_strobe,
  output logic      [7:0] wr_data,
  output logic            rd_strobe
);
  initial
  begin
    page = 1'b0;
    cmd_code = 8'h00;
    wr_strobe = 1'b0;
    wr_data = 8'h00;
    rd_strobe = 1'b0;
  end

  // one-cycle write pulse, reject seen after the taking edge
  task automatic wr(input logic [7:0] c, input logic [7:0] d,
                    output logic rej);
    cmd_code = c;
    wr_data = d;
    wr_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    rej = cmd_reject;
    wr_strobe = 1'b0;
    wr_data = ~d;
    cmd_code = ~c;
    // idle edge so the next request never re-raises the strobe at once
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] c, output logic [8:0] got);
    cmd_code = c;
    rd_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    got = {rd_valid, rd_data};
    rd_strobe = 1'b0;
    cmd_code = ~c;
    @(posedge core_clk);
    #1;
  endtask
endmodule

/* ocr_tb.sv */
`timescale 1ns/100ps
module tb;
  localparam int MS = 4;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        page, wr_strobe, rd_strobe, rd_valid, cmd_reject;
  logic [7:0]  cmd_code, wr_data, rd_data, nvm_cfg, v;
  logic        clear_faults, restore_user_all, vendor_soft_reset_cmd;
  logic        run_pin, operation_on, oc_detect, other_fault_shutdown;
  logic        alert_mask, output_enable, current_limit_active;
  logic        st_nota, st_ioc, st_word, st_flt, smbalert_oe, r;
  logic        alert_lvl;
  logic [15:0] restart_interval_setting;
  logic [8:0]  got;
  logic [31:0] seed = 32'h3CBE3324;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          d;

  always #2.5 core_clk = ~core_clk;

  ocr_host_model host (.core_clk(core_clk), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_reject(cmd_reject), .page(page),
    .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe));

  ocr_overcurrent_response #(.MS_TICK_CYCLES(MS)) uut (
    .core_clk(core_clk), .resetn(resetn), .page(page),
    .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_reject(cmd_reject), .clear_faults(clear_faults),
    .restore_user_all(restore_user_all),
    .vendor_soft_reset_cmd(vendor_soft_reset_cmd), .nvm_cfg(nvm_cfg),
    .run_pin(run_pin), .operation_on(operation_on),
    .oc_detect(oc_detect), .other_fault_shutdown(other_fault_shutdown),
    .alert_mask(alert_mask),
    .restart_interval_setting(restart_interval_setting),
    .output_enable(output_enable),
    .current_limit_active(current_limit_active),
    .status_none_of_above(st_nota), .status_iout_oc(st_ioc),
    .status_word_iout(st_word), .status_iout_oc_fault(st_flt),
    .smbalert_out(alert_lvl), .smbalert_oe(smbalert_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_rej(input logic [7:0] c, input logic [7:0] x);
    return (c != 8'h47) || (x[7:6] == 2'h1);
  endfunction

  function automatic int exp_hold(input logic [7:0] cfg);
    return int'(cfg[2:0]) * 16 * MS;
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wchk(input logic [7:0] c, input logic [7:0] x);
    host.wr(c, x, r);
    chk("reject", exp_rej(c, x), r);
  endtask

  task automatic rchk(input logic [7:0] c, input logic [7:0] e);
    host.rd(c, got);
    chk("read", {1'b1, e}, got);
  endtask

  task automatic power_on();
    oc_detect = 1'b0;
    run_pin = 1'b1;
    cyc(3);
    chk("oe_on", 1'b1, output_enable);
  endtask

  // program response, clear old faults, then raise the comparator
  task automatic trip(input logic [7:0] cfg, input logic m);
    wchk(8'h47, cfg);
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    alert_mask = m;
    oc_detect = 1'b1;
    cyc(1);
    chk("status", {4'hF, !m}, {st_nota, st_ioc, st_word, st_flt, smbalert_oe});
    chk("alert_lvl", 1'b0, alert_lvl);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    {clear_faults, restore_user_all, vendor_soft_reset_cmd} = 3'h0;
    {run_pin, operation_on, oc_detect, other_fault_shutdown} = 4'h4;
    alert_mask = 1'b0;
    nvm_cfg = 8'h00;
    restart_interval_setting = 16'h0000;
    repeat (5) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    rchk(8'h47, 8'h00);
    rchk(8'hD6, 8'hC0);
    wchk(8'hD6, 8'h00);
    rchk(8'hD6, 8'hC0);
    wchk(8'h47, 8'h45);
    wchk(8'h55, 8'h12);
    repeat (8)
    begin
      v = 8'(rnd());
      wchk(8'h47, v);
      if (!exp_rej(8'h47, v))
        rchk(8'h47, v);
    end
    wchk(8'h47, 8'h80);
    host.page = 1'b1;
    host.wr(8'h47, 8'hC7, r);
    chk("page_ign", 1'b0, r);
    host.page = 1'b0;
    rchk(8'h47, 8'h80);
    $display("test registers done");
    power_on();
    trip(8'h00, 1'b0);
    chk("cc_run", 2'h3, {output_enable, current_limit_active});
    oc_detect = 1'b0;
    cyc(20);
    chk("sticky", 1'b1, st_flt);
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    chk("cleared", 5'h00, {st_nota, st_ioc, st_word, st_flt, smbalert_oe});
    trip(8'hC3, 1'b0);
    chk("shut", 1'b0, output_enable);
    oc_detect = 1'b0;
    cyc(300);
    chk("latched", 1'b0, output_enable);
    run_pin = 1'b0;
    cyc(2);
    power_on();
    chk("run_clear", 1'b0, st_flt);
    $display("test shutdown done");
    d = 1 + int'(rnd() % 4);
    restart_interval_setting = 16'(d);
    trip(8'hF8, 1'b1);
    chk("retry_off", 1'b0, output_enable);
    oc_detect = 1'b0;
    cyc(d * MS);
    chk("retry_wait", 1'b0, output_enable);
    cyc(1);
    chk("retry_on", 1'b1, output_enable);
    other_fault_shutdown = 1'b1;
    cyc(3);
    chk("other_flt", 1'b0, output_enable);
    other_fault_shutdown = 1'b0;
    run_pin = 1'b0;
    cyc(2);
    power_on();
    $display("test retry done");
    v = {5'b10000, 3'(1 + rnd() % 3)};
    trip(v, 1'b0);
    cyc(20);
    oc_detect = 1'b0;
    cyc(exp_hold(v));
    chk("recover", 1'b1, output_enable);
    trip(v, 1'b0);
    cyc(exp_hold(v));
    chk("hold_on", 1'b1, output_enable);
    cyc(1);
    chk("hold_off", 1'b0, output_enable);
    $display("test delayed done");
    nvm_cfg = 8'hBA;
    restore_user_all = 1'b1;
    cyc(1);
    restore_user_all = 1'b0;
    chk("restore", 1'b0, st_flt);
    rchk(8'h47, 8'hBA);
    run_pin = 1'b0;
    cyc(2);
    power_on();
    trip(8'h00, 1'b0);
    nvm_cfg = 8'h9D;
    oc_detect = 1'b0;
    vendor_soft_reset_cmd = 1'b1;
    cyc(1);
    vendor_soft_reset_cmd = 1'b0;
    chk("soft_rst", 1'b0, st_flt);
    rchk(8'h47, 8'h9D);
    trip(8'h00, 1'b0);
    oc_detect = 1'b0;
    operation_on = 1'b0;
    cyc(2);
    chk("op_off", 1'b0, output_enable);
    operation_on = 1'b1;
    cyc(2);
    chk("op_clear", 2'h2, {output_enable, st_flt});
    $display("test reload done");
    tally_and_finish();
  end
endmodule
